// [bench/ivr_mem_model.sv]
// Memory partner of the resolver: answers vector reads after a set number of wait cycles.
// Assumes the resolver holds address and width until acknowledged, on the CPU clock.
`timescale 1ns/1ps
`default_nettype none
module ivr_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mem_req_i,
  input wire logic mem_word_i,
  input wire logic [19:0] mem_addr_i,
  input wire logic [3:0] wait_i,
  input wire logic probe_ff_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o
);
  import ivr_pkg::*;
  logic [3:0] cnt;
  logic flip;
  // Contents follow the address so that every byte of a vector differs
  function automatic logic [7:0] mem_byte(input logic [19:0] a);
    if (a == BRK_PROBE_ADDR && probe_ff_i) begin
      return BRK_PROBE_EMPTY;
    end
    return a[7:0] ^ 8'h3C;
  endfunction : mem_byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
      cnt <= (mem_ack_o || !mem_req_i) ? 4'h0 : cnt + 4'h1;
    end
  end
  // Outside the ack a toggling pattern, so stale data is never mistaken for an answer
  always_comb begin
    mem_ack_o = mem_req_i && (cnt >= wait_i);
    mem_rdata_o = {16{flip}} ^ 16'hA5A5;
    if (mem_ack_o) begin
      mem_rdata_o = {mem_word_i ? mem_byte(mem_addr_i + 20'h1) : ~mem_byte(mem_addr_i), mem_byte(mem_addr_i)};
    end
  end
endmodule : ivr_mem_model
`default_nettype wire

// [bench/ivr_top_bench.sv]
// Self-checking bench for the resolver: fixed, break, software and peripheral takes.
// Assumes the memory partner model and the resolver package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ivr_top_bench;
  import ivr_pkg::*;
  logic sys_clk = 0, rst = 1, global_en = 0, sw_req = 0, probe_ff = 0;
  ivr_periph_t periph = '0;
  ivr_route_t route = '0;
  logic [NUM_VEC-1:0][LVL_W-1:0] level = '0;
  logic [NUM_VEC-1:0] pend_clr = '0;
  logic [LVL_W-1:0] processor_priority_level = '0;
  logic [NUM_FIX-1:0] special = '0;
  logic [5:0] sw_num = '0;
  logic [19:0] vbase = '0;
  logic [3:0] wait_cyc = '0;
  logic mem_req, mem_word, mem_ack, pc_load, take, take_fixed, busy;
  logic [19:0] mem_addr, pc;
  logic [15:0] rdata;
  logic [5:0] take_num;
  logic [LVL_W-1:0] take_level;
  logic [NUM_VEC-1:0] pend;
  int error_cnt = 0, n_compared = 0, cycles = 0;
  ivr_top i_ivr_top (.SYS_CLK_I(sys_clk), .RST_I(rst), .PERIPH_I(periph), .ROUTE_I(route), .LEVEL_I(level),
    .PEND_CLR_I(pend_clr), .GLOBAL_EN_I(global_en), .IPL_I(processor_priority_level), .SPECIAL_I(special), .SW_REQ_I(sw_req),
    .SW_NUM_I(sw_num), .VECTOR_BASE_I(vbase), .MEM_REQ_O(mem_req), .MEM_WORD_O(mem_word), .MEM_ADDR_O(mem_addr),
    .MEM_ACK_I(mem_ack), .MEM_RDATA_I(rdata), .PC_LOAD_O(pc_load), .PC_O(pc), .TAKE_O(take),
    .TAKE_FIXED_O(take_fixed), .TAKE_NUM_O(take_num), .TAKE_LEVEL_O(take_level), .BUSY_O(busy), .PEND_O(pend));
  ivr_mem_model i_ivr_mem_model (.clk_i(sys_clk), .rst_i(rst), .mem_req_i(mem_req), .mem_word_i(mem_word),
    .mem_addr_i(mem_addr), .wait_i(wait_cyc), .probe_ff_i(probe_ff), .mem_ack_o(mem_ack), .mem_rdata_o(rdata));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // Generous ceiling; the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step
  function automatic logic [7:0] mb(input logic [19:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction : mb
  function automatic logic [19:0] vec_pc(input logic [19:0] a);
    logic [7:0] b2;
    b2 = mb(a + 20'h2);
    return {b2[3:0], mb(a + 20'h1), mb(a)};
  endfunction : vec_pc
  // Runs one take to the PC load; returns the first read address and the cycle count
  task automatic run(output logic [19:0] first, output int cyc);
    int tk;
    bit seen;
    tk = 0;
    seen = 0;
    cyc = 0;
    first = '0;
    while (cyc < 60) begin
      step();
      // Drop pulses once; the caller drives them next
      if (cyc == 0) begin
        special = '0;
        sw_req = 1'b0;
      end
      cyc++;
      if (take === 1'b1) tk++;
      if (mem_req === 1'b1 && !seen) begin
        first = mem_addr;
        seen = 1;
      end
      if (pc_load === 1'b1) break;
    end
    chk(tk, 1);
    chk(pc_load, 1'b1);
  endtask : run
  task automatic t_fixed();
    logic [19:0] a;
    int c;
    vbase = 20'h1_2344;
    for (int i = 0; i < NUM_FIX; i++) begin
      special = 9'h1 << i;
      run(a, c);
      chk(a, (i == 2) ? BRK_PROBE_ADDR : FIX_TABLE_LO + 20'(4 * i));
      chk(pc, vec_pc(FIX_TABLE_LO + 20'(4 * i)));
      chk(take_fixed, 1'b1);
    end
    special = 9'h081;
    run(a, c);
    chk(take_num, 7);
    chk(a, 20'hF_FFF8);
    chk(pc, vec_pc(20'hF_FFF8));
    probe_ff = 1'b1;
    special = 9'h4;
    run(a, c);
    chk(pc, vec_pc(vbase));
    probe_ff = 1'b0;
    $display("fixed table test done");
  endtask : t_fixed
  task automatic t_soft();
    int nums[4] = '{0, 32, 45, 63};
    int ce;
    int co;
    logic [19:0] a;
    wait_cyc = 4'h2;
    for (int i = 0; i < 4; i++) begin
      sw_num = 6'(nums[i]);
      sw_req = 1'b1;
      run(a, ce);
      chk(a, vbase + 20'(4 * nums[i]));
      chk(pc, vec_pc(vbase + 20'(4 * nums[i])));
      chk(take_num, nums[i]);
    end
    wait_cyc = 4'h0;
    vbase = 20'h0_2000;
    sw_req = 1'b1;
    run(a, ce);
    vbase = 20'h0_2001;
    sw_req = 1'b1;
    run(a, co);
    chk(pc, vec_pc(20'h0_20FD));
    chk(co > ce, 1);
    $display("software table test done");
  endtask : t_soft
  // Pulses one source bit and expects exactly one pending vector, or none
  task automatic hit(input int k, input int v);
    periph[k] = 1'b1;
    step();
    periph = '0;
    step();
    step();
    chk(pend, (v < 0) ? 32'h0 : 32'h1 << v);
    pend_clr = '1;
    step();
    pend_clr = '0;
  endtask : hit
  task automatic t_map();
    int ka[34] = '{38, 35, 36, 37, 33, 34, 32, 31, 8, 9, 10, 11, 12, 2, 3, 4, 7, 6, 5, 0, 1, 40, 39, 30, 27, 28,
      25, 29, 26, 18, 17, 16, 22, 15};
    int va[34] = '{4, 29, 30, 31, 11, 12, 13, 14, 21, 22, 23, 24, 25, 26, 27, 28, 5, 6, 7, 8, 9, -1, -1, 15, 16, 17,
      18, 19, 20, 10, -1, -1, -1, -1};
    int kb[17] = '{40, 39, 0, 6, 5, 17, 16, 18, 15, 14, 13, 24, 21, 22, 19, 23, 20};
    int vb[17] = '{8, 9, -1, -1, -1, -1, -1, -1, 10, 6, 7, 15, 16, 17, 18, 19, 20};
    global_en = 1'b0;
    route = '0;
    for (int i = 0; i < 34; i++) hit(ka[i], va[i]);
    // All selects to the alternate source and every channel in I2C mode
    route = '1;
    for (int i = 0; i < 17; i++) hit(kb[i], vb[i]);
    route = '0;
    $display("source map test done");
  endtask : t_map
  task automatic t_mask();
    logic [19:0] a;
    int c;
    vbase = 20'h0_3000;
    processor_priority_level = 3'h3;
    level[21] = 3'h3;
    global_en = 1'b1;
    periph.timer_a[0] = 1'b1;
    step();
    periph = '0;
    repeat (4) step();
    chk(pend[21], 1'b1);
    chk(busy, 1'b0);
    level[21] = 3'h4;
    global_en = 1'b0;
    repeat (4) step();
    chk(busy, 1'b0);
    global_en = 1'b1;
    run(a, c);
    chk(a, 20'h0_3054);
    chk(pc, vec_pc(20'h0_3054));
    chk(take_num, 21);
    chk(take_level, 3'h4);
    chk(take_fixed, 1'b0);
    chk(pend[21], 1'b0);
    global_en = 1'b0;
    level = '0;
    $display("maskable accept test done");
  endtask : t_mask
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk(busy, 1'b0);
    chk(pend, 32'h0);
    chk(pc_load, 1'b0);
    step();
    t_fixed();
    t_soft();
    t_map();
    t_mask();
    report_and_stop();
  end
endmodule : ivr_top_bench
`default_nettype wire

// [inc/ivr_pkg.sv]
// Package for the interrupt vector resolver: table addresses, vector numbers, carrier types.
// Assumes a 20-bit address space and a CPU-clocked sequencer on the far side.
package ivr_pkg;
  localparam int ADDR_W = 20;
  localparam int LVL_W = 3;
  localparam int NUM_VEC = 32;
  localparam int VEC_PERIPH_LO = 4;
  localparam int VEC_BYTES = 4;
  localparam int RELOC_BYTES = 256;
  localparam logic [19:0] FIX_TABLE_LO = 20'hF_FFDC;
  localparam logic [19:0] FIX_TABLE_HI = 20'hF_FFFF;
  localparam logic [19:0] BRK_PROBE_ADDR = 20'hF_FFE7;
  localparam logic [7:0] BRK_PROBE_EMPTY = 8'hFF;
  localparam logic [5:0] SW_UNMASKED_LO = 6'h20;
  // Relocatable vector numbers of the peripheral sources
  localparam int VEC_EXT3 = 4;
  localparam int VEC_TB5 = 5;
  localparam int VEC_SHARE6 = 6;
  localparam int VEC_SHARE7 = 7;
  localparam int VEC_SHARE8 = 8;
  localparam int VEC_SHARE9 = 9;
  localparam int VEC_COL2 = 10;
  localparam int VEC_DMA0 = 11;
  localparam int VEC_KEY = 13;
  localparam int VEC_ADC = 14;
  localparam int VEC_SER_TX0 = 15;
  localparam int VEC_TA0 = 21;
  localparam int VEC_TB0 = 26;
  localparam int VEC_EXT0 = 29;

  // Fixed vector slots, four bytes apart from the table bottom
  typedef enum logic [3:0] {
    IVR_FIX_UNDEF = 4'h0,
    IVR_FIX_OVF = 4'h1,
    IVR_FIX_BRK = 4'h2,
    IVR_FIX_ADDR_MATCH = 4'h3,
    IVR_FIX_STEP = 4'h4,
    IVR_FIX_WDT_GROUP = 4'h5,
    IVR_FIX_DEBUG = 4'h6,
    IVR_FIX_NMI = 4'h7,
    IVR_FIX_RESET = 4'h8
  } ivr_fix_t;
  localparam int NUM_FIX = 9;

  typedef enum logic [1:0] {
    IVR_IDLE = 2'b00,
    IVR_PROBE = 2'b01,
    IVR_FETCH = 2'b11,
    IVR_DONE = 2'b10
  } ivr_state_t;

  // Serial channel order: index 0, 1, 2 for channels zero, one and two
  typedef struct packed {
    logic [5:0] ext_irq;
    logic [1:0] dma;
    logic key;
    logic adc;
    logic [2:0] ser_tx;
    logic [2:0] ser_rx;
    logic [2:0] ser_nack;
    logic [2:0] ser_ack;
    logic [2:0] ser_collision;
    logic [2:0] ser_start_stop;
    logic [4:0] timer_a;
    logic [5:0] timer_b;
    logic clocked_serial_three;
    logic clocked_serial_four;
  } ivr_periph_t;

  // Select bit 1 picks the external input or the collision source
  typedef struct packed {
    logic vec6_source_select;
    logic vec7_source_select;
    logic vec8_source_select;
    logic vec9_source_select;
    logic [2:0] i2c_mode;
  } ivr_route_t;
endpackage : ivr_pkg

// [verilog/ivr_src_map.sv]
// Maps peripheral event pulses onto relocatable vector numbers 4 to 31.
// Assumes event pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ivr_src_map (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ivr_pkg::ivr_periph_t periph_i,
  input wire ivr_pkg::ivr_route_t route_i,
  output logic [ivr_pkg::NUM_VEC-1:0] req_o
);
  import ivr_pkg::*;

  logic [2:0] col_event;

  always_comb begin
    col_event = '0;
    for (int c = 0; c < 3; c++) begin
      col_event[c] = route_i.i2c_mode[c] ? periph_i.ser_start_stop[c] : periph_i.ser_collision[c];
    end
  end

  always_comb begin
    req_o = '0; // Numbers 0 to 3 never carry a source
    req_o[VEC_EXT3] = periph_i.ext_irq[3];
    req_o[VEC_TB5] = periph_i.timer_b[5];
    req_o[VEC_SHARE6] = route_i.vec6_source_select ? col_event[1] : periph_i.timer_b[4];
    req_o[VEC_SHARE7] = route_i.vec7_source_select ? col_event[0] : periph_i.timer_b[3];
    req_o[VEC_SHARE8] = route_i.vec8_source_select ? periph_i.ext_irq[5] : periph_i.clocked_serial_four;
    req_o[VEC_SHARE9] = route_i.vec9_source_select ? periph_i.ext_irq[4] : periph_i.clocked_serial_three;
    req_o[VEC_COL2] = col_event[2];
    req_o[VEC_DMA0 +: 2] = periph_i.dma;
    req_o[VEC_KEY] = periph_i.key;
    req_o[VEC_ADC] = periph_i.adc;
    // Channel order in the table is two, zero, one
    for (int k = 0; k < 3; k++) begin
      int ch;
      ch = (k + 2) % 3;
      req_o[VEC_SER_TX0 + 2*k] = route_i.i2c_mode[ch] ? periph_i.ser_nack[ch] : periph_i.ser_tx[ch];
      req_o[VEC_SER_TX0 + 2*k + 1] = route_i.i2c_mode[ch] ? periph_i.ser_ack[ch] : periph_i.ser_rx[ch];
    end
    req_o[VEC_TA0 +: 5] = periph_i.timer_a;
    req_o[VEC_TB0 +: 3] = periph_i.timer_b[2:0];
    req_o[VEC_EXT0 +: 3] = periph_i.ext_irq[2:0];
  end

  property p_vec8_select;
    @(posedge clk_i) disable iff (rst_i)
    route_i.vec8_source_select |-> req_o[VEC_SHARE8] == periph_i.ext_irq[5];
  endproperty
  a_vec8_select: assert property (p_vec8_select) else $error("Vector 8 not from chosen source");

  property p_i2c_nack;
    @(posedge clk_i) disable iff (rst_i)
    route_i.i2c_mode[2] |-> req_o[VEC_SER_TX0] == periph_i.ser_nack[2] && req_o[VEC_SER_TX0+1] == periph_i.ser_ack[2];
  endproperty
  a_i2c_nack: assert property (p_i2c_nack) else $error("I2C vectors not from ack events");

  property p_collision_mode;
    @(posedge clk_i) disable iff (rst_i)
    !route_i.i2c_mode[2] |-> req_o[VEC_COL2] == periph_i.ser_collision[2];
  endproperty
  a_collision_mode: assert property (p_collision_mode) else $error("Collision vector wrong in IE mode");
endmodule : ivr_src_map
`default_nettype wire

// [verilog/ivr_top.sv]
// Interrupt vector resolver: accepts a request, fetches its 4-byte vector, loads the PC.
// Assumes a CPU-clocked memory port that answers with MEM_ACK_I and a sequencer that waits on BUSY_O.
`timescale 1ns/1ps
`default_nettype none
module ivr_top (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire ivr_pkg::ivr_periph_t PERIPH_I,
  input wire ivr_pkg::ivr_route_t ROUTE_I,
  input wire logic [ivr_pkg::NUM_VEC-1:0][ivr_pkg::LVL_W-1:0] LEVEL_I,
  input wire logic [ivr_pkg::NUM_VEC-1:0] PEND_CLR_I,
  input wire logic GLOBAL_EN_I,
  input wire logic [ivr_pkg::LVL_W-1:0] IPL_I,
  input wire logic [ivr_pkg::NUM_FIX-1:0] SPECIAL_I,
  input wire logic SW_REQ_I,
  input wire logic [5:0] SW_NUM_I,
  input wire logic [ivr_pkg::ADDR_W-1:0] VECTOR_BASE_I,
  output logic MEM_REQ_O,
  output logic MEM_WORD_O,
  output logic [ivr_pkg::ADDR_W-1:0] MEM_ADDR_O,
  input wire logic MEM_ACK_I,
  input wire logic [15:0] MEM_RDATA_I,
  output logic PC_LOAD_O,
  output logic [ivr_pkg::ADDR_W-1:0] PC_O,
  output logic TAKE_O,
  output logic TAKE_FIXED_O,
  output logic [5:0] TAKE_NUM_O,
  output logic [ivr_pkg::LVL_W-1:0] TAKE_LEVEL_O,
  output logic BUSY_O,
  output logic [ivr_pkg::NUM_VEC-1:0] PEND_O
);
  import ivr_pkg::*;

  logic [NUM_VEC-1:0] raw_req;
  ivr_state_t state, next_state;
  logic [NUM_VEC-1:0] pend, next_pend;
  logic reloc, next_reloc;
  logic [5:0] num, next_num;
  logic [3:0] fix, next_fix;
  logic [1:0] part, next_part;
  logic [31:0] vec, next_vec;
  logic [ADDR_W-1:0] base, next_base;
  logic [ADDR_W-1:0] pc, next_pc;
  logic pc_load, next_pc_load;
  logic take, next_take;
  logic take_fixed, next_take_fixed;
  logic [5:0] take_num, next_take_num;
  logic [LVL_W-1:0] take_level, next_take_level;
  logic [NUM_VEC-1:0] take_clr;
  logic best_found;
  logic [4:0] best_num;
  logic [LVL_W-1:0] best_lvl;
  logic spec_any;
  logic [3:0] spec_idx;
  logic [ADDR_W-1:0] vec_addr;
  logic word_mode;
  logic [1:0] last_part;

  ivr_src_map u_src_map (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .periph_i(PERIPH_I),
    .route_i(ROUTE_I),
    .req_o(raw_req)
  );

  // Highest level wins; ties go to the lower number
  always_comb begin
    best_found = 1'b0;
    best_num = '0;
    best_lvl = '0;
    for (int i = VEC_PERIPH_LO; i < NUM_VEC; i++) begin
      if (pend[i] && LEVEL_I[i] > IPL_I && (!best_found || LEVEL_I[i] > best_lvl)) begin
        best_found = 1'b1;
        best_num = 5'(i);
        best_lvl = LEVEL_I[i];
      end
    end
  end

  // Highest special index wins, so reset beats everything
  always_comb begin
    spec_any = 1'b0;
    spec_idx = '0;
    for (int j = 0; j < NUM_FIX; j++) begin
      if (SPECIAL_I[j]) begin
        spec_any = 1'b1;
        spec_idx = 4'(j);
      end
    end
  end

  always_comb begin
    if (reloc) begin
      vec_addr = base + {12'h000, num, 2'b00};
    end else begin
      vec_addr = FIX_TABLE_LO + {14'h0000, fix, 2'b00};
    end
    // Odd addresses cost byte reads, so an even base is faster
    word_mode = ~vec_addr[0];
    last_part = word_mode ? 2'd1 : 2'd3;
  end

  always_comb begin
    MEM_REQ_O = (state == IVR_PROBE) || (state == IVR_FETCH);
    MEM_WORD_O = (state == IVR_FETCH) && word_mode;
    if (state == IVR_PROBE) begin
      MEM_ADDR_O = BRK_PROBE_ADDR;
    end else if (word_mode) begin
      MEM_ADDR_O = vec_addr + {17'h0_0000, part, 1'b0};
    end else begin
      MEM_ADDR_O = vec_addr + {18'h0_0000, part};
    end
  end

  always_comb begin
    next_state = state;
    next_reloc = reloc;
    next_num = num;
    next_fix = fix;
    next_part = part;
    next_vec = vec;
    next_base = base;
    next_pc = pc;
    next_pc_load = 1'b0;
    next_take = 1'b0;
    next_take_fixed = take_fixed;
    next_take_num = take_num;
    next_take_level = take_level;
    take_clr = '0;
    unique case (state)
      IVR_IDLE: begin
        next_part = '0;
        next_base = VECTOR_BASE_I;
        if (spec_any) begin
          next_reloc = 1'b0;
          next_fix = spec_idx;
          next_take = 1'b1;
          next_take_fixed = 1'b1;
          next_take_num = {2'b00, spec_idx};
          next_take_level = '0;
          next_state = (spec_idx == IVR_FIX_BRK) ? IVR_PROBE : IVR_FETCH;
        end else if (SW_REQ_I) begin
          // Instruction interrupts never look at the enable flag
          next_reloc = 1'b1;
          next_num = SW_NUM_I;
          next_take = 1'b1;
          next_take_fixed = 1'b0;
          next_take_num = SW_NUM_I;
          next_take_level = '0;
          next_state = IVR_FETCH;
        end else if (GLOBAL_EN_I && best_found) begin
          next_reloc = 1'b1;
          next_num = {1'b0, best_num};
          next_take = 1'b1;
          next_take_fixed = 1'b0;
          next_take_num = {1'b0, best_num};
          next_take_level = best_lvl;
          take_clr[best_num] = 1'b1;
          next_state = IVR_FETCH;
        end
      end
      IVR_PROBE: begin
        if (MEM_ACK_I) begin
          if (MEM_RDATA_I[7:0] == BRK_PROBE_EMPTY) begin
            next_reloc = 1'b1;
            next_num = '0;
          end
          next_state = IVR_FETCH;
        end
      end
      IVR_FETCH: begin
        if (MEM_ACK_I) begin
          // Low address first, little-endian assembly
          if (word_mode) begin
            next_vec[{part[0], 4'h0} +: 16] = MEM_RDATA_I;
          end else begin
            next_vec[{part, 3'h0} +: 8] = MEM_RDATA_I[7:0];
          end
          if (part == last_part) begin
            next_state = IVR_DONE;
          end else begin
            next_part = part + 2'd1;
          end
        end
      end
      IVR_DONE: begin
        next_pc = vec[ADDR_W-1:0];
        next_pc_load = 1'b1;
        next_state = IVR_IDLE;
      end
    endcase
    // A new event beats any clear in the same cycle
    next_pend = ((pend & ~PEND_CLR_I & ~take_clr) | raw_req) & ~NUM_VEC'(4'hF);
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= IVR_IDLE;
      pend <= '0;
      reloc <= 1'b0;
      num <= '0;
      fix <= '0;
      part <= '0;
      vec <= '0;
      base <= '0;
      pc <= '0;
      pc_load <= 1'b0;
      take <= 1'b0;
      take_fixed <= 1'b0;
      take_num <= '0;
      take_level <= '0;
    end else begin
      state <= next_state;
      pend <= next_pend;
      reloc <= next_reloc;
      num <= next_num;
      fix <= next_fix;
      part <= next_part;
      vec <= next_vec;
      base <= next_base;
      pc <= next_pc;
      pc_load <= next_pc_load;
      take <= next_take;
      take_fixed <= next_take_fixed;
      take_num <= next_take_num;
      take_level <= next_take_level;
    end
  end

  assign PC_LOAD_O = pc_load;
  assign PC_O = pc;
  assign TAKE_O = take;
  assign TAKE_FIXED_O = take_fixed;
  assign TAKE_NUM_O = take_num;
  assign TAKE_LEVEL_O = take_level;
  assign BUSY_O = (state != IVR_IDLE);
  assign PEND_O = pend;

  property p_fixed_range;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    MEM_REQ_O && !reloc |-> MEM_ADDR_O >= FIX_TABLE_LO && MEM_ADDR_O <= FIX_TABLE_HI;
  endproperty
  a_fixed_range: assert property (p_fixed_range) else $error("Fixed fetch outside fixed table");

  property p_reloc_addr;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    state == IVR_FETCH && reloc && part == 2'd0 |-> MEM_ADDR_O == base + {12'h000, num, 2'b00};
  endproperty
  a_reloc_addr: assert property (p_reloc_addr) else $error("Relocatable vector address wrong");

  property p_odd_bytes;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    MEM_REQ_O && reloc && base[0] |-> !MEM_WORD_O;
  endproperty
  a_odd_bytes: assert property (p_odd_bytes) else $error("Odd base fetched by words");

  property p_probe_redirect;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    state == IVR_PROBE && MEM_ACK_I && MEM_RDATA_I[7:0] == BRK_PROBE_EMPTY |=> reloc && num == 6'h00;
  endproperty
  a_probe_redirect: assert property (p_probe_redirect) else $error("Break not redirected to entry zero");

  property p_mask_accept;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    TAKE_O && !TAKE_FIXED_O && TAKE_LEVEL_O != 3'd0 |-> $past(GLOBAL_EN_I) && TAKE_LEVEL_O > $past(IPL_I);
  endproperty
  a_mask_accept: assert property (p_mask_accept) else $error("Maskable accepted against gating");

  property p_done_load;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    state == IVR_DONE |=> PC_LOAD_O && PC_O == $past(vec[19:0]) && !BUSY_O;
  endproperty
  a_done_load: assert property (p_done_load) else $error("PC not loaded from vector");

  property p_sw_unmasked;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    state == IVR_IDLE && !spec_any && SW_REQ_I && SW_NUM_I >= SW_UNMASKED_LO |=> TAKE_O && BUSY_O;
  endproperty
  a_sw_unmasked: assert property (p_sw_unmasked) else $error("Software interrupt not taken");

  // A fresh event on the same vector legally keeps the flag, so it is excluded
  property p_pend_clear;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    state == IVR_IDLE && !spec_any && !SW_REQ_I && GLOBAL_EN_I && best_found && !raw_req[best_num] |=>
      TAKE_O && !pend[$past(best_num)];
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("Accepted request left pending");
endmodule : ivr_top
`default_nettype wire
